// [rtl/dpw_pkg.sv]
// Purpose: Shared constants and types of the wiper serial interface.
// Assumes: Bytes arrive most significant bit first.
// Notes:   Address byte is seven address bits then the direction bit.
package dpw_pkg;

    localparam logic [4:0] ADDR_FIXED   = 5'h0B;
    localparam int         ADR_FIX_LSB  = 3;
    localparam int         ADR_STRAP_HI = 2;
    localparam int         ADR_STRAP_LO = 1;
    localparam int         ADR_RW       = 0;

    localparam int         INS_CHAN     = 7;
    localparam int         INS_CENTER   = 6;
    localparam int         INS_PDOWN    = 5;
    localparam int         INS_GP_TWO   = 4;
    localparam int         INS_GP_ONE   = 3;

    localparam logic [7:0] WIPER_MID    = 8'h80;
    localparam logic [3:0] BIT_LAST     = 4'h7;
    localparam logic [3:0] BIT_ACK      = 4'h8;

    typedef enum logic [9:0] {
        S_IDLE      = 10'h001,
        S_ADDR      = 10'h002,
        S_ADDR_ACK  = 10'h004,
        S_INSTR     = 10'h008,
        S_INSTR_ACK = 10'h010,
        S_DATA      = 10'h020,
        S_DATA_ACK  = 10'h040,
        S_READ      = 10'h080,
        S_READ_ACK  = 10'h100,
        S_IGNORE    = 10'h200
    } dpw_state_e;

endpackage

// [rtl/dpw_line_if.sv]
// Purpose: Bus line events passed between the wiper interface modules.
// Assumes: All signals are on the mclk_in domain.
// Notes:   Events are single-cycle pulses; sda_level is a level.
`timescale 1ns/1ps
interface dpw_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic sda_level;
    modport src (output scl_rise, scl_fall, start_cond, stop_cond,
                 sda_level);
    modport dst (input  scl_rise, scl_fall, start_cond, stop_cond,
                 sda_level);
endinterface

// [rtl/dpw_line_sync.sv]
// Purpose: Synchronise the bus lines and find edges, start and stop.
// Assumes: Bus clock is far slower than mclk_in.
// Notes:   Lines reset to the released (high) level.
`timescale 1ns/1ps
module dpw_line_sync (
    input  wire logic mclk_in,
    input  wire logic rst_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    dpw_line_if.src   ln
);
    logic [1:0] scl_q;
    logic [1:0] sda_q;
    logic       scl_d;
    logic       sda_d;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            scl_q <= 2'h3;
            sda_q <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_q <= {scl_q[0], scl_in};
            sda_q <= {sda_q[0], sda_in};
            scl_d <= scl_q[1];
            sda_d <= sda_q[1];
        end
    end

    assign ln.scl_rise   = scl_q[1] & ~scl_d;
    assign ln.scl_fall   = ~scl_q[1] & scl_d;
    // SDA moving while SCL stays high marks a frame boundary
    assign ln.start_cond = scl_q[1] & scl_d & sda_d & ~sda_q[1];
    assign ln.stop_cond  = scl_q[1] & scl_d & ~sda_d & sda_q[1];
    assign ln.sda_level  = sda_q[1];
endmodule

// [rtl/dpw_bit_shift.sv]
// Purpose: Sample serial bits and count the nine clocks of each byte.
// Assumes: Line events come from dpw_line_sync.
// Notes:   Count 8 is the acknowledge slot; the count wraps after it.
`timescale 1ns/1ps
module dpw_bit_shift
    import dpw_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    dpw_line_if.dst         ln,
    output logic [7:0]      rx_byte_out,
    output logic [3:0]      bit_cnt_out
);
    // The SCL fall that closes a start wraps the count to zero
    always_ff @(posedge mclk_in) begin
        if (rst_in || ln.stop_cond) begin
            bit_cnt_out <= 4'h0;
        end else if (ln.start_cond) begin
            bit_cnt_out <= BIT_ACK;
        end else if (ln.scl_fall) begin
            bit_cnt_out <= (bit_cnt_out == BIT_ACK) ? 4'h0
                         : 4'(bit_cnt_out + 4'h1);
        end
    end

    // Data is taken while SCL is high, so changes in the low phase pass
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rx_byte_out <= 8'h00;
        end else if (ln.scl_rise) begin
            rx_byte_out <= {rx_byte_out[6:0], ln.sda_level};
        end
    end
endmodule

// [rtl/dpw_top.sv]
// Purpose: Serial target interface of a one or two wiper potentiometer.
// Assumes: rst_in is the power-on preset; pins are asynchronous.
// Notes:   SDA is open drain: sda_oe_out high pulls the line low.
//
// Behaviour
// - Address is fixed 01011 followed by the two strap bits.
// - Addressed only when both strap bits match the strap pins.
// - On address match, pull SDA low in the ninth clock.
// - Unaddressed device stays idle with SDA released.
// - Direction bit high reads from device, low writes to it.
// - Instruction top bit selects wiper one or two; single part uses 0.
// - Second instruction bit moves selected wiper to midscale.
// - Third instruction bit shuts down selected channel, like the pin.
// - Next two instruction bits set output two then output one.
// - Three low instruction bits are ignored.
// - Wiper data byte follows the instruction and is acknowledged.
// - SDA changes only while SCL low, except start and stop.
// - Read drives wiper code after address ack; controller answers NACK.
// - Each further data byte updates the selected wiper.
// - Each further read byte returns the wiper code again.
// - Read returns the channel last selected by a write instruction.
// - Power-on presets each wiper to midscale.
// - Shutdown keeps the stored wiper code and reapplies it later.
// - Both logic outputs are low until programmed.
// - Instruction shutdown is left when a new command arrives.
`timescale 1ns/1ps
module dpw_top
    import dpw_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       addr_strap_low_in,
    input  wire logic       addr_strap_high_in,
    input  wire logic       power_down_pin_n_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic [7:0]      wiper_one_out,
    output logic [7:0]      wiper_two_out,
    output logic [1:0]      power_down_out,
    output logic            gp_output_one_out,
    output logic            gp_output_two_out
);
    generate
        if (CHANNELS < 1 || CHANNELS > 2) begin : g_bad_chan
            $error("CHANNELS must be 1 or 2");
        end
    endgenerate

    dpw_line_if ln ();

    logic [7:0] rx;
    logic [3:0] bit_cnt;

    dpw_line_sync u_sync (
        .mclk_in (mclk_in),
        .rst_in  (rst_in),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .ln      (ln.src)
    );

    dpw_bit_shift u_shift (
        .mclk_in     (mclk_in),
        .rst_in      (rst_in),
        .ln          (ln.dst),
        .rx_byte_out (rx),
        .bit_cnt_out (bit_cnt)
    );

    // Straps and shutdown pin pass two flops before use
    logic [2:0] pin_q1;
    logic [2:0] pin_q2;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pin_q1 <= 3'h4;
            pin_q2 <= 3'h4;
        end else begin
            pin_q1 <= {power_down_pin_n_in, addr_strap_high_in,
                       addr_strap_low_in};
            pin_q2 <= pin_q1;
        end
    end

    wire strap_lo   = pin_q2[0];
    wire strap_hi   = pin_q2[1];
    wire pd_pin_n   = pin_q2[2];

    dpw_state_e state;
    dpw_state_e next_state;
    logic       next_oe;
    logic [7:0] tx;
    logic [7:0] next_tx;
    logic       rd_mode;
    logic       sel_chan;
    logic [1:0] pdown_bit;

    wire byte_end = ln.scl_fall && (bit_cnt == BIT_LAST);
    wire ack_end  = ln.scl_fall && (bit_cnt == BIT_ACK);

    wire addr_hit = (rx[7:ADR_FIX_LSB] == ADDR_FIXED)
                 && (rx[ADR_STRAP_HI] == strap_hi)
                 && (rx[ADR_STRAP_LO] == strap_lo);

    // Single-channel part always lands on wiper one
    wire ins_chan = (CHANNELS == 2) ? rx[INS_CHAN] : 1'b0;
    wire [7:0] sel_wiper = sel_chan ? wiper_two_out
                                    : wiper_one_out;

    wire addr_take  = byte_end && (state == S_ADDR);
    wire instr_take = byte_end && (state == S_INSTR);
    wire data_take  = byte_end && (state == S_DATA);
    wire nack_seen  = rx[0];

    // A start from any state re-arms, so repeated starts switch modes
    always_comb begin
        next_state = state;
        next_oe    = sda_oe_out;
        next_tx    = tx;
        if (ln.start_cond) begin
            next_state = S_ADDR;
            next_oe    = 1'b0;
        end else if (ln.stop_cond) begin
            next_state = S_IDLE;
            next_oe    = 1'b0;
        end else if (byte_end) begin
            case (state)
                S_ADDR: begin
                    next_state = addr_hit ? S_ADDR_ACK : S_IGNORE;
                    next_oe    = addr_hit;
                end
                S_INSTR: begin
                    next_state = S_INSTR_ACK;
                    next_oe    = 1'b1;
                end
                S_DATA: begin
                    next_state = S_DATA_ACK;
                    next_oe    = 1'b1;
                end
                S_READ: begin
                    next_state = S_READ_ACK;
                    next_oe    = 1'b0;
                end
                default: begin
                    next_state = state;
                end
            endcase
        end else if (ack_end) begin
            case (state)
                S_ADDR_ACK: begin
                    if (rd_mode) begin
                        next_state = S_READ;
                        next_tx    = sel_wiper;
                        next_oe    = ~sel_wiper[7];
                    end else begin
                        next_state = S_INSTR;
                        next_oe    = 1'b0;
                    end
                end
                S_INSTR_ACK, S_DATA_ACK: begin
                    next_state = S_DATA;
                    next_oe    = 1'b0;
                end
                S_READ_ACK: begin
                    if (nack_seen) begin
                        next_state = S_IGNORE;
                        next_oe    = 1'b0;
                    end else begin
                        next_state = S_READ;
                        next_tx    = sel_wiper;
                        next_oe    = ~sel_wiper[7];
                    end
                end
                default: begin
                    next_state = state;
                end
            endcase
        end else if (ln.scl_fall && state == S_READ) begin
            // Next bit goes out in the low phase of SCL
            next_tx = {tx[6:0], 1'b0};
            next_oe = ~tx[6];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state      <= S_IDLE;
            sda_oe_out <= 1'b0;
            sda_out    <= 1'b0;
            tx         <= 8'h00;
        end else begin
            state      <= next_state;
            sda_oe_out <= next_oe;
            sda_out    <= 1'b0;
            tx         <= next_tx;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_mode <= 1'b0;
        end else if (addr_take) begin
            rd_mode <= rx[ADR_RW];
        end
    end

    // Instruction fields; the three low bits are never looked at
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sel_chan          <= 1'b0;
            pdown_bit         <= 2'h0;
            gp_output_one_out <= 1'b0;
            gp_output_two_out <= 1'b0;
        end else if (instr_take) begin
            sel_chan          <= ins_chan;
            // Any new instruction clears the older software shutdown
            pdown_bit         <= {ins_chan & rx[INS_PDOWN],
                                  ~ins_chan & rx[INS_PDOWN]};
            gp_output_two_out <= rx[INS_GP_TWO];
            gp_output_one_out <= rx[INS_GP_ONE];
        end
    end

    // Codes are kept through shutdown and come back unchanged
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wiper_one_out <= WIPER_MID;
            wiper_two_out <= WIPER_MID;
        end else if (instr_take && rx[INS_CENTER]) begin
            if (ins_chan) begin
                wiper_two_out <= WIPER_MID;
            end else begin
                wiper_one_out <= WIPER_MID;
            end
        end else if (data_take) begin
            if (sel_chan) begin
                wiper_two_out <= rx;
            end else begin
                wiper_one_out <= rx;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            power_down_out <= 2'h0;
        end else begin
            power_down_out <= pdown_bit | {2{~pd_pin_n}};
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_addr_hit;
        addr_take && addr_hit;
    endsequence

    sequence s_addr_miss;
        addr_take && !addr_hit;
    endsequence

    sequence s_read_open;
        ack_end && state == S_ADDR_ACK && rd_mode;
    endsequence

    sequence s_instr_ch0;
        instr_take && !ins_chan;
    endsequence

    addr_ack_a: assert property (
        s_addr_hit |=> sda_oe_out && state == S_ADDR_ACK)
        else $error("address match not acknowledged");

    addr_miss_a: assert property (
        s_addr_miss |=> state == S_IGNORE && !sda_oe_out)
        else $error("wrong address was taken");

    idle_release_a: assert property (
        state == S_IGNORE || state == S_IDLE |-> !sda_oe_out)
        else $error("SDA driven while not addressed");

    read_first_a: assert property (
        s_read_open |=> tx == $past(sel_wiper)
                        && sda_oe_out == !tx[7])
        else $error("read byte not loaded from wiper");

    center_tap_a: assert property (
        s_instr_ch0 ##0 rx[INS_CENTER] |=> wiper_one_out == WIPER_MID)
        else $error("midscale preset not applied");

    gp_level_a: assert property (
        instr_take |=> gp_output_two_out == $past(rx[INS_GP_TWO])
                       && gp_output_one_out == $past(rx[INS_GP_ONE]))
        else $error("logic outputs not updated");

    data_write_a: assert property (
        data_take && !sel_chan |=> wiper_one_out == $past(rx))
        else $error("data byte did not reach wiper one");

    pin_down_a: assert property (
        !pd_pin_n |=> power_down_out == 2'h3)
        else $error("shutdown pin not honoured");

    reset_value_a: assert property (
        $fell(rst_in) |-> wiper_two_out == WIPER_MID
                          && !gp_output_one_out && !gp_output_two_out)
        else $error("power-on preset wrong");

    ack_release_a: assert property (
        ack_end && (state == S_INSTR_ACK || state == S_DATA_ACK)
        |=> !sda_oe_out && state == S_DATA)
        else $error("ack slot not released");

    sequence s_read_more;
        ack_end && state == S_READ_ACK && !nack_seen;
    endsequence

    read_again_a: assert property (
        s_read_more |=> state == S_READ && tx == $past(sel_wiper))
        else $error("repeated read did not reload code");

    oe_timing_a: assert property (
        $changed(sda_oe_out) |-> $past(ln.scl_fall)
                                 || $past(ln.start_cond)
                                 || $past(ln.stop_cond))
        else $error("SDA drive changed outside SCL low");

    soft_down_a: assert property (
        instr_take && rx[INS_PDOWN] |-> ##2 power_down_out != 2'h0)
        else $error("shutdown bit not applied");

    code_kept_a: assert property (
        power_down_out != 2'h0 && !$past(instr_take) && !$past(data_take)
        |-> $stable(wiper_one_out) && $stable(wiper_two_out))
        else $error("wiper code lost in shutdown");
endmodule

// [verif/dpw_ctl_model.sv]
// Purpose: Bus controller model that drives SCL and SDA for the target.
// Assumes: SDA has a pull-up; sda_low_out high pulls the wire low.
// Notes:   SCL rests high between frames; results toggle res_tgl_out.
`timescale 1ns/1ps
module dpw_ctl_model (
    input  wire logic       mclk_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            sda_low_out,
    output logic            res_tgl_out,
    output logic [8:0]      res_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        res_tgl_out = 1'b0;
        res_out = 9'h000;
    end

    // Data moves one mclk after SCL falls, clear of the high phase
    task automatic clk_bit(input logic b, output logic s);
        @(negedge mclk_in);
        sda_low_out = ~b;
        repeat (3) @(negedge mclk_in);
        scl_out = 1'b1;
        repeat (4) @(negedge mclk_in);
        s = sda_in;
        scl_out = 1'b0;
    endtask

    task automatic emit(input logic [8:0] v);
        res_out = v;
        res_tgl_out = ~res_tgl_out;
    endtask

    task automatic start_c;
        @(negedge mclk_in);
        sda_low_out = 1'b0;
        repeat (3) @(negedge mclk_in);
        scl_out = 1'b1;
        repeat (4) @(negedge mclk_in);
        sda_low_out = 1'b1;
        repeat (4) @(negedge mclk_in);
        scl_out = 1'b0;
    endtask

    // Pulls SDA low first, so a stop after a read NACK is well formed
    task automatic stop_c;
        @(negedge mclk_in);
        sda_low_out = 1'b1;
        repeat (3) @(negedge mclk_in);
        scl_out = 1'b1;
        repeat (4) @(negedge mclk_in);
        sda_low_out = 1'b0;
        repeat (4) @(negedge mclk_in);
    endtask

    task automatic send_byte(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], s);
        end
        clk_bit(1'b1, s);
        emit({s, 8'h00});
    endtask

    task automatic recv_byte(input logic ack);
        logic       s;
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            clk_bit(1'b1, s);
            r = {r[6:0], s};
        end
        clk_bit(ack, s);
        emit({1'b0, r});
    endtask
endmodule

// [verif/dpw_top_tb_top.sv]
// Purpose: Self-checking bench of the wiper serial target.
// Assumes: Controller model owns SCL; SDA is wired-AND with a pull-up.
// Notes:   Bus results are queued and matched by a monitor process.
`timescale 1ns/1ps
module dpw_top_tb_top;
    import dpw_pkg::*;
    logic       mclk_in;
    logic       rst_in;
    logic [1:0] st;
    logic       pin_n;
    logic       scl;
    logic       sda_low;
    logic       sda_w;
    logic       res_tgl;
    logic [8:0] res;
    logic       sda_o;
    logic       sda_oe;
    logic [7:0] w1_o;
    logic [7:0] w2_o;
    logic [1:0] pd_o;
    logic       gp1;
    logic       gp2;
    logic [8:0] exp_q[$];
    logic [7:0] w1;
    logic [7:0] w2;
    logic [7:0] d;
    logic       m;
    int         err_total = 0;
    int         tests_run = 0;
    int         cyc = 0;
    int         seed = 11122;

    assign sda_w = ~((sda_oe & ~sda_o) | sda_low);

    dpw_top #(.CHANNELS(2)) dut (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .scl_in(scl),
        .sda_in(sda_w),
        .addr_strap_low_in(st[0]),
        .addr_strap_high_in(st[1]),
        .power_down_pin_n_in(pin_n),
        .sda_out(sda_o),
        .sda_oe_out(sda_oe),
        .wiper_one_out(w1_o),
        .wiper_two_out(w2_o),
        .power_down_out(pd_o),
        .gp_output_one_out(gp1),
        .gp_output_two_out(gp2)
    );

    dpw_ctl_model ctl (
        .mclk_in(mclk_in),
        .sda_in(sda_w),
        .scl_out(scl),
        .sda_low_out(sda_low),
        .res_tgl_out(res_tgl),
        .res_out(res)
    );

    initial mclk_in = 1'b0;
    always #12.5 mclk_in = ~mclk_in;

    task automatic complete_run;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_res(input logic [8:0] e, input logic [8:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] bus result exp %h got %h", e, g);
            err_total++;
        end
    endtask

    task automatic chk_out(input string n, input logic [7:0] e,
                           input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            err_total++;
        end
    endtask

    // An empty queue yields a value no bus result can carry
    always @(res_tgl) begin
        if ($time > 0) begin
            chk_res((exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF, res);
        end
    end

    // Hang guard; a full run needs about 7000 cycles
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            complete_run;
        end
    end

    task automatic tx(input logic [7:0] b, input logic ack);
        exp_q.push_back({ack, 8'h00});
        ctl.send_byte(b);
    endtask

    task automatic rx(input logic [7:0] e, input logic more);
        exp_q.push_back({1'b0, e});
        ctl.recv_byte(~more);
    endtask

    task automatic cmd(input logic [7:0] ins);
        ctl.start_c;
        tx({ADDR_FIXED, st, 1'b0}, 1'b0);
        tx(ins, 1'b0);
    endtask

    task automatic chk_pins(input logic [1:0] pd, input logic [1:0] gp);
        chk_out("wiper one", w1, w1_o);
        chk_out("wiper two", w2, w2_o);
        chk_out("power down", {6'h00, pd}, {6'h00, pd_o});
        chk_out("gp outputs", {6'h00, gp}, {6'h00, gp2, gp1});
    endtask

    initial begin
        rst_in = 1'b1;
        st = 2'b10;
        pin_n = 1'b1;
        w1 = WIPER_MID;
        w2 = WIPER_MID;
        repeat (4) @(negedge mclk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        chk_pins(2'b00, 2'b00);
        // Output two set alone shows bit order; low bits are junk
        cmd(8'h15);
        d = 8'($random(seed));
        tx(d, 1'b0);
        w1 = 8'($random(seed));
        tx(w1, 1'b0);
        ctl.stop_c;
        chk_pins(2'b00, 2'b10);
        for (int s = 0; s < 4; s++) begin
            for (int a = 0; a < 5; a++) begin
                st = s[1:0];
                m = (a == s);
                d = 8'($random(seed));
                ctl.start_c;
                if (a == 4) begin
                    tx({5'h1B, st, 1'b0}, 1'b1);
                end else begin
                    tx({ADDR_FIXED, a[1:0], 1'b0}, ~m);
                end
                tx(8'h88, ~m);
                tx(d, ~m);
                ctl.stop_c;
                if (m) begin
                    w2 = d;
                end
                chk_pins(2'b00, 2'b01);
            end
        end
        // Read each channel after a bare instruction and repeated start
        for (int c = 0; c < 2; c++) begin
            cmd({c[0], 7'h00});
            ctl.start_c;
            tx({ADDR_FIXED, st, 1'b1}, 1'b0);
            rx(c[0] ? w2 : w1, 1'b1);
            rx(c[0] ? w2 : w1, 1'b0);
            ctl.stop_c;
        end
        chk_pins(2'b00, 2'b00);
        for (int c = 0; c < 2; c++) begin
            cmd({c[0], 7'h40});
            ctl.stop_c;
            if (c == 0) begin
                w1 = WIPER_MID;
            end else begin
                w2 = WIPER_MID;
            end
            chk_pins(2'b00, 2'b00);
            cmd({c[0], 7'h20});
            ctl.stop_c;
            chk_pins(c[0] ? 2'b10 : 2'b01, 2'b00);
            cmd(8'h00);
            ctl.stop_c;
            chk_pins(2'b00, 2'b00);
        end
        pin_n = 1'b0;
        repeat (6) @(negedge mclk_in);
        chk_pins(2'b11, 2'b00);
        pin_n = 1'b1;
        repeat (6) @(negedge mclk_in);
        chk_pins(2'b00, 2'b00);
        chk_out("queue left", 8'h00, 8'(exp_q.size()));
        complete_run;
    end
endmodule
